/* inc/fap_pkg.sv */
// Purpose: Shared constants for the flash access protection block.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses on wb_adr.
// Notes: Register map, code storage, flag positions and command fields follow.
package fap_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FAP_ADR_MODE = 8'h00;
  localparam logic [7:0] FAP_ADR_CMD = 8'h04;
  localparam logic [7:0] FAP_ADR_STATUS = 8'h08;
  localparam logic [7:0] FAP_ADR_PROT = 8'h0c;
  localparam logic [7:0] FAP_ADR_DBG_ENTRY = 8'h10;
  localparam logic [7:0] FAP_ADR_DBG_CTRL = 8'h14;
  localparam logic [7:0] FAP_ADR_DBG_STAT = 8'h18;
  localparam logic [7:0] FAP_ADR_ID_BASE = 8'h20;
  // ---------------------------------------------------------------------------
  // Code storage
  // ---------------------------------------------------------------------------
  localparam int FAP_ID_BYTES = 10;
  localparam logic [15:0] FAP_ID_FLASH_FIRST = 16'h0070;
  localparam logic [15:0] FAP_ID_FLASH_LAST = 16'h0079;
  localparam logic [3:0] FAP_FLAG_BYTE = 4'h9;
  localparam int FAP_FLAG_BIT = 7;
  localparam logic [7:0] FAP_ERASED_BYTE = 8'hff;
  localparam logic [3:0] FAP_IDX_LAST = 4'h9;
  // ---------------------------------------------------------------------------
  // Protection flag positions
  // ---------------------------------------------------------------------------
  localparam int FAP_PROT_WRITE = 0;
  localparam int FAP_PROT_CHIP = 1;
  localparam int FAP_PROT_BLOCK = 2;
  localparam int FAP_PROT_READ = 3;
  localparam int FAP_PROT_BOOT = 4;
  localparam logic [4:0] FAP_PROT_RESET = 5'h00;
  // ---------------------------------------------------------------------------
  // Command fields, mode bits and status bits
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {FAP_OP_READ, FAP_OP_WRITE, FAP_OP_BLOCK, FAP_OP_CHIP} fap_op_type;
  localparam int FAP_CMD_BOOT = 2;
  localparam int FAP_MODE_ACTIVE = 0;
  localparam int FAP_MODE_SELF = 1;
  localparam int FAP_STAT_GRANT = 1;
  localparam int FAP_STAT_REFUSE = 2;
endpackage

/* hdl/fap_id_compare.sv */
// Purpose: Byte-serial comparison of an entered code against the stored code.
// Assumes: Inputs hold steady from start until done.
// Notes: One byte per cycle; done pulses ten cycles after the start edge.
module fap_id_compare (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire logic [79:0] entered,
  input wire logic [79:0] stored,
  output logic done_r,
  output logic match_r
);
  typedef enum logic {FAP_CMP_IDLE, FAP_CMP_RUN} fap_cmp_type;
  fap_cmp_type state_r, state_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic miss_r, miss_nxt;
  logic done_nxt, match_nxt;

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    miss_nxt = miss_r;
    done_nxt = 1'b0;
    match_nxt = match_r;
    unique case (state_r)
      FAP_CMP_IDLE: begin
        if (start) begin
          state_nxt = FAP_CMP_RUN;
          idx_nxt = 4'h0;
          miss_nxt = 1'b0;
        end
      end
      FAP_CMP_RUN: begin
        // A single differing byte anywhere spoils the whole code.
        if (entered[idx_r * 8 +: 8] != stored[idx_r * 8 +: 8]) begin
          miss_nxt = 1'b1;
        end
        idx_nxt = idx_r + 4'h1;
        if (idx_r == fap_pkg::FAP_IDX_LAST) begin
          state_nxt = FAP_CMP_IDLE;
          done_nxt = 1'b1;
          match_nxt = !(miss_nxt);
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= FAP_CMP_IDLE;
      idx_r <= 4'h0;
      miss_r <= 1'b0;
      done_r <= 1'b0;
      match_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      miss_r <= miss_nxt;
      done_r <= done_nxt;
      match_r <= match_nxt;
    end
  end
endmodule // fap_id_compare

/* hdl/fap_flash_access_protection.sv */
// Purpose: Gatekeeper for debug attach and programmer access to on-chip flash.
// Assumes: Classic Wishbone slave; one register per aligned word.
// Notes: The code bytes and protection flags stand for the flash extra area.
module fap_flash_access_protection (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  output logic debug_granted,
  output logic op_granted,
  output logic op_refused
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0] id_r [fap_pkg::FAP_ID_BYTES];
  logic [7:0] id_nxt [fap_pkg::FAP_ID_BYTES];
  logic [79:0] entry_r, entry_nxt;
  logic [79:0] id_flat;
  logic [4:0] prot_r, prot_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [7:0] rbyte_r, rbyte_nxt;
  logic [31:0] dat_r_nxt;
  logic ack_nxt;
  logic grant_r, grant_nxt;
  logic refuse_r, refuse_nxt;
  logic dbg_grant_r, dbg_grant_nxt;
  logic dbg_deny_r, dbg_deny_nxt;
  logic dbg_busy_r, dbg_busy_nxt;
  logic lock_r, lock_nxt;
  logic cmp_start;
  logic cmp_done;
  logic cmp_match;
  logic bus_req;
  logic bus_wr;
  logic [31:0] wdata;
  logic op_req;
  logic op_ok;
  logic reprog;
  logic chip_erased;
  fap_pkg::fap_op_type op_code;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] fap_lane_mask(input logic [3:0] sel, input logic [31:0] d);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i * 8 +: 8] = sel[i] ? d[i * 8 +: 8] : 8'h00;
    end
    return m;
  endfunction

  // Outside self-programming every active flag vetoes on its own, so restrictions add up; self-programming heeds only the boot flag.
  function automatic logic fap_op_allowed(input fap_pkg::fap_op_type op, input logic self_prog,
                                          input logic boot, input logic [4:0] p);
    logic ok;
    logic boot_lock;
    ok = 1'b0;
    boot_lock = boot && p[fap_pkg::FAP_PROT_BOOT];
    if (self_prog) begin
      unique case (op)
        fap_pkg::FAP_OP_READ: ok = 1'b1;
        fap_pkg::FAP_OP_WRITE: ok = !boot_lock;
        fap_pkg::FAP_OP_BLOCK: ok = !boot_lock;
        fap_pkg::FAP_OP_CHIP: ok = 1'b0;
      endcase
    end else begin
      unique case (op)
        fap_pkg::FAP_OP_READ: ok = !p[fap_pkg::FAP_PROT_READ];
        fap_pkg::FAP_OP_WRITE: ok = !p[fap_pkg::FAP_PROT_WRITE] && !boot_lock;
        fap_pkg::FAP_OP_BLOCK: ok = !p[fap_pkg::FAP_PROT_WRITE] && !p[fap_pkg::FAP_PROT_CHIP]
                                    && !p[fap_pkg::FAP_PROT_BLOCK] && !boot_lock;
        fap_pkg::FAP_OP_CHIP: ok = !p[fap_pkg::FAP_PROT_CHIP]
                                   && !p[fap_pkg::FAP_PROT_BOOT];
      endcase
    end
    return ok;
  endfunction

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  assign bus_req = wb_cyc && wb_stb && !wb_ack;
  assign bus_wr = bus_req && wb_we;
  assign wdata = fap_lane_mask(wb_sel, wb_dat_w);
  assign op_code = fap_pkg::fap_op_type'(wdata[1:0]);
  // Programmer operations count only inside a reprogramming session.
  assign op_req = bus_wr && (wb_adr == fap_pkg::FAP_ADR_CMD) && mode_r[fap_pkg::FAP_MODE_ACTIVE];
  assign op_ok = fap_op_allowed(op_code, mode_r[fap_pkg::FAP_MODE_SELF],
                                wdata[fap_pkg::FAP_CMD_BOOT], prot_r);
  assign chip_erased = op_req && op_ok && (op_code == fap_pkg::FAP_OP_CHIP);
  assign reprog = op_req && op_ok && (op_code != fap_pkg::FAP_OP_READ);

  always_comb begin
    for (int i = 0; i < fap_pkg::FAP_ID_BYTES; i++) begin
      id_flat[i * 8 +: 8] = id_r[i];
    end
  end

  fap_id_compare u_compare (
    .clock(clock),
    .rstn(rstn),
    .start(cmp_start),
    .entered(entry_r),
    .stored(id_flat),
    .done_r(cmp_done),
    .match_r(cmp_match)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [3:0] idx;
    logic wr_boot;
    idx = wdata[7:4];
    wr_boot = wdata[fap_pkg::FAP_CMD_BOOT];
    id_nxt = id_r;
    entry_nxt = entry_r;
    prot_nxt = prot_r;
    mode_nxt = mode_r;
    rbyte_nxt = rbyte_r;
    grant_nxt = grant_r;
    refuse_nxt = refuse_r;
    dbg_grant_nxt = dbg_grant_r;
    dbg_deny_nxt = dbg_deny_r;
    dbg_busy_nxt = dbg_busy_r;
    lock_nxt = lock_r;
    cmp_start = 1'b0;
    ack_nxt = bus_req;
    dat_r_nxt = 32'h0000_0000;
    if (bus_wr) begin
      unique case (wb_adr)
        fap_pkg::FAP_ADR_MODE: begin
          mode_nxt = wdata[1:0];
        end
        fap_pkg::FAP_ADR_PROT: begin
          // Flags only ever gain bits here; clearing needs a chip erase.
          // An external change is blocked once chip erase protection is on.
          if (mode_r[fap_pkg::FAP_MODE_ACTIVE] && (mode_r[fap_pkg::FAP_MODE_SELF]
              || !prot_r[fap_pkg::FAP_PROT_CHIP])) begin
            prot_nxt = prot_r | wdata[4:0];
          end
        end
        fap_pkg::FAP_ADR_DBG_ENTRY: begin
          entry_nxt = {wdata[7:0], entry_r[79:8]};
        end
        fap_pkg::FAP_ADR_DBG_CTRL: begin
          if (wdata[0] && !dbg_busy_r) begin
            dbg_grant_nxt = 1'b0;
            // Flag clear: no comparison at all, and the port locks.
            if (!id_r[fap_pkg::FAP_FLAG_BYTE][fap_pkg::FAP_FLAG_BIT]) begin
              dbg_deny_nxt = 1'b1;
              lock_nxt = 1'b1;
            end else if (lock_r) begin
              dbg_deny_nxt = 1'b1;
            end else begin
              dbg_deny_nxt = 1'b0;
              dbg_busy_nxt = 1'b1;
              cmp_start = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (op_req) begin
      grant_nxt = op_ok;
      refuse_nxt = !op_ok;
      rbyte_nxt = 8'h00;
      if (op_ok) begin
        unique case (op_code)
          fap_pkg::FAP_OP_READ: begin
            if (idx < 4'(fap_pkg::FAP_ID_BYTES)) begin
              rbyte_nxt = id_r[idx];
            end
          end
          fap_pkg::FAP_OP_WRITE: begin
            // The code sits in the boot block, so writes must name it.
            if (wr_boot && idx < 4'(fap_pkg::FAP_ID_BYTES)) begin
              id_nxt[idx] = wdata[15:8];
            end
          end
          fap_pkg::FAP_OP_BLOCK: begin
            if (wr_boot) begin
              for (int i = 0; i < fap_pkg::FAP_ID_BYTES; i++) begin
                id_nxt[i] = fap_pkg::FAP_ERASED_BYTE;
              end
            end
          end
          fap_pkg::FAP_OP_CHIP: begin
            for (int i = 0; i < fap_pkg::FAP_ID_BYTES; i++) begin
              id_nxt[i] = fap_pkg::FAP_ERASED_BYTE;
            end
            prot_nxt = fap_pkg::FAP_PROT_RESET;
          end
        endcase
      end
    end
    // Any accepted change to flash lifts the prohibition lock.
    if (reprog) begin
      lock_nxt = 1'b0;
    end
    if (cmp_done) begin
      dbg_busy_nxt = 1'b0;
      dbg_grant_nxt = cmp_match;
      dbg_deny_nxt = !cmp_match;
    end
    if (bus_req && !wb_we) begin
      unique case (wb_adr)
        fap_pkg::FAP_ADR_MODE: dat_r_nxt = {30'h0, mode_r};
        fap_pkg::FAP_ADR_STATUS: dat_r_nxt = {16'h0, rbyte_r, 5'h0, refuse_r, grant_r, 1'b0};
        fap_pkg::FAP_ADR_PROT: dat_r_nxt = {27'h0, prot_r};
        fap_pkg::FAP_ADR_DBG_STAT: dat_r_nxt = {28'h0, lock_r, dbg_deny_r, dbg_grant_r,
                                                dbg_busy_r};
        default: dat_r_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < fap_pkg::FAP_ID_BYTES; i++) begin
        id_r[i] <= fap_pkg::FAP_ERASED_BYTE;
      end
      entry_r <= 80'h0;
      prot_r <= fap_pkg::FAP_PROT_RESET;
      mode_r <= 2'h0;
      rbyte_r <= 8'h00;
      grant_r <= 1'b0;
      refuse_r <= 1'b0;
      dbg_grant_r <= 1'b0;
      dbg_deny_r <= 1'b0;
      dbg_busy_r <= 1'b0;
      lock_r <= 1'b0;
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
      debug_granted <= 1'b0;
      op_granted <= 1'b0;
      op_refused <= 1'b0;
    end else begin
      id_r <= id_nxt;
      entry_r <= entry_nxt;
      prot_r <= prot_nxt;
      mode_r <= mode_nxt;
      rbyte_r <= rbyte_nxt;
      grant_r <= grant_nxt;
      refuse_r <= refuse_nxt;
      dbg_grant_r <= dbg_grant_nxt;
      dbg_deny_r <= dbg_deny_nxt;
      dbg_busy_r <= dbg_busy_nxt;
      lock_r <= lock_nxt;
      wb_ack <= ack_nxt;
      wb_dat_r <= dat_r_nxt;
      debug_granted <= dbg_grant_nxt;
      op_granted <= grant_nxt;
      op_refused <= refuse_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_flag_zero_deny: assert property (
    (bus_wr && wb_adr == fap_pkg::FAP_ADR_DBG_CTRL && wdata[0] && !dbg_busy_r
     && !id_r[fap_pkg::FAP_FLAG_BYTE][fap_pkg::FAP_FLAG_BIT])
    |=> (!debug_granted && dbg_deny_r && lock_r && !dbg_busy_r))
    else $error("session with flag clear was not refused");

  chk_grant_by_match: assert property (
    $rose(debug_granted) |-> $past(cmp_done) && $past(cmp_match))
    else $error("debug granted without a full code match");

  chk_lock_holds: assert property (
    (lock_r && !reprog) |=> lock_r)
    else $error("debug lock released without reprogramming");

  chk_read_hidden: assert property (
    (op_req && op_code == fap_pkg::FAP_OP_READ && !mode_r[fap_pkg::FAP_MODE_SELF]
     && prot_r[fap_pkg::FAP_PROT_READ]) |=> op_refused && rbyte_r == 8'h00)
    else $error("protected read returned data");

  chk_write_prot: assert property (
    (op_req && !mode_r[fap_pkg::FAP_MODE_SELF] && prot_r[fap_pkg::FAP_PROT_WRITE]
     && (op_code == fap_pkg::FAP_OP_WRITE || op_code == fap_pkg::FAP_OP_BLOCK))
    |=> op_refused && !op_granted)
    else $error("write protection ignored");

  chk_chip_prot: assert property (
    (op_req && !mode_r[fap_pkg::FAP_MODE_SELF] && prot_r[fap_pkg::FAP_PROT_CHIP]
     && (op_code == fap_pkg::FAP_OP_CHIP || op_code == fap_pkg::FAP_OP_BLOCK))
    |=> op_refused)
    else $error("chip erase protection ignored");

  chk_flags_grow: assert property (
    !chip_erased |=> ((prot_r & $past(prot_r)) == $past(prot_r)))
    else $error("protection flag cleared without chip erase");

  chk_self_write: assert property (
    (op_req && mode_r[fap_pkg::FAP_MODE_SELF] && op_code == fap_pkg::FAP_OP_WRITE
     && !wdata[fap_pkg::FAP_CMD_BOOT]) |=> op_granted ##1 !op_refused[*1])
    else $error("self-programming write refused");

  chk_boot_guard: assert property (
    (op_req && prot_r[fap_pkg::FAP_PROT_BOOT] && wdata[fap_pkg::FAP_CMD_BOOT]
     && op_code != fap_pkg::FAP_OP_READ) |=> op_refused)
    else $error("boot block changed under protection");

  chk_lock_denies: assert property (
    (bus_wr && wb_adr == fap_pkg::FAP_ADR_DBG_CTRL && wdata[0] && !dbg_busy_r && lock_r)
    |=> (dbg_deny_r && !dbg_grant_r && !debug_granted && !dbg_busy_r))
    else $error("locked debug port started a session");

  chk_block_prot: assert property (
    (op_req && !mode_r[fap_pkg::FAP_MODE_SELF] && prot_r[fap_pkg::FAP_PROT_BLOCK]
     && op_code == fap_pkg::FAP_OP_BLOCK) |=> op_refused && !op_granted)
    else $error("block erase protection ignored");

  chk_self_no_chip: assert property (
    (op_req && mode_r[fap_pkg::FAP_MODE_SELF] && op_code == fap_pkg::FAP_OP_CHIP)
    |=> op_refused && $stable(prot_r))
    else $error("self-programming chip erase accepted");

  chk_self_read: assert property (
    (op_req && mode_r[fap_pkg::FAP_MODE_SELF] && op_code == fap_pkg::FAP_OP_READ)
    |=> op_granted && !op_refused)
    else $error("self-programming read refused");

  chk_prot_frozen: assert property (
    (bus_wr && wb_adr == fap_pkg::FAP_ADR_PROT && !mode_r[fap_pkg::FAP_MODE_SELF]
     && prot_r[fap_pkg::FAP_PROT_CHIP]) |=> $stable(prot_r))
    else $error("external flag change under chip erase protection");
endmodule // fap_flash_access_protection

/* verification/fap_prog_model.sv */
// Purpose: Bus-side model of the external programmer and debug emulator.
// Assumes: Classic Wishbone, one request at a time, answer sampled at rising edges.
// Notes: Released lines carry inverted values so stale data never passes.
module fap_prog_model (
  input wire logic clock,
  input wire logic wb_ack,
  input wire logic [31:0] wb_dat_r,
  output logic wb_cyc,
  output logic wb_stb,
  output logic wb_we,
  output logic [7:0] wb_adr,
  output logic [3:0] wb_sel,
  output logic [31:0] wb_dat_w
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat_w = 32'h0000_0000;
  end
  // The request stands until ack is sampled, then drops for one idle cycle.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rdat);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= dat;
    @(posedge clock);
    while (wb_ack !== 1'b1) @(posedge clock);
    rdat = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= ~we;
    wb_adr <= ~adr;
    wb_dat_w <= ~dat;
    @(posedge clock);
  endtask
endmodule // fap_prog_model

/* verification/test_flash_access_protection.sv */
// Purpose: Self-checking bench for the flash access protection block.
// Assumes: Each bus request is answered one cycle after it is taken.
// Notes: Flags clear only by chip erase or reset, so the flag scenario starts from reset.
module test_flash_access_protection;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Signals and helpers
  // ---------------------------------------------------------------------------
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic debug_granted;
  logic op_granted;
  logic op_refused;
  int num_errors = 0;
  int checks_done = 0;
  fap_flash_access_protection u_dut (.clock(clock), .rstn(rstn), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .debug_granted(debug_granted),
    .op_granted(op_granted), .op_refused(op_refused));
  fap_prog_model u_host (.clock(clock), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w));
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_host.xfer(1'b1, a, d, r);
  endtask
  task automatic ck_prot(input logic [31:0] exp);
    logic [31:0] r;
    u_host.xfer(1'b0, fap_pkg::FAP_ADR_PROT, 32'h0, r);
    check(r, exp);
  endtask
  task automatic mode(input logic self_m);
    wr(fap_pkg::FAP_ADR_MODE, {30'h0, self_m, 1'b1});
  endtask
  task automatic cmd(input logic [1:0] op, input logic boot, input logic [3:0] idx,
                     input logic [7:0] d, input logic ok);
    logic [31:0] r;
    wr(fap_pkg::FAP_ADR_CMD, {16'h0, d, idx, 1'b0, boot, op});
    u_host.xfer(1'b0, fap_pkg::FAP_ADR_STATUS, 32'h0, r);
    check({30'h0, r[fap_pkg::FAP_STAT_REFUSE], r[fap_pkg::FAP_STAT_GRANT]},
          {30'h0, ~ok, ok});
    check({30'h0, op_refused, op_granted}, {30'h0, ~ok, ok});
    // A refused read must leave no flash byte behind in the status word.
    if (op == fap_pkg::FAP_OP_READ) begin
      check({24'h0, r[15:8]}, {24'h0, ok ? d : 8'h00});
    end
  endtask
  // Code bytes go in byte 0 first; the bench polls busy with a bounded count.
  task automatic debug_try(input logic [79:0] code, input logic grant, input logic lock);
    logic [31:0] r;
    int n;
    for (int i = 0; i < fap_pkg::FAP_ID_BYTES; i++) begin
      wr(fap_pkg::FAP_ADR_DBG_ENTRY, {24'h0, code[8*i +: 8]});
    end
    wr(fap_pkg::FAP_ADR_DBG_CTRL, 32'h1);
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 40) begin
      u_host.xfer(1'b0, fap_pkg::FAP_ADR_DBG_STAT, 32'h0, r);
      n++;
    end
    check({28'h0, r[3:0]}, {28'h0, lock, ~grant, grant, 1'b0});
    check({31'h0, debug_granted}, {31'h0, grant});
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_debug();
    wr(8'h3c, 32'hffff_ffff);
    ck_prot(32'h0);
    debug_try({80{1'b1}}, 1'b1, 1'b0);
    debug_try({{40{1'b1}}, 8'hfe, {32{1'b1}}}, 1'b0, 1'b0);
    mode(1'b0);
    cmd(fap_pkg::FAP_OP_WRITE, 1'b1, 4'h9, 8'h7f, 1'b1);
    debug_try({80{1'b1}}, 1'b0, 1'b1);
    debug_try({8'h7f, {72{1'b1}}}, 1'b0, 1'b1);
    cmd(fap_pkg::FAP_OP_BLOCK, 1'b1, 4'h0, 8'h00, 1'b1);
    debug_try({80{1'b1}}, 1'b1, 1'b0);
    cmd(fap_pkg::FAP_OP_WRITE, 1'b1, 4'h0, 8'h5a, 1'b1);
    cmd(fap_pkg::FAP_OP_READ, 1'b0, 4'h0, 8'h5a, 1'b1);
    debug_try({{72{1'b1}}, 8'h5a}, 1'b1, 1'b0);
    debug_try({80{1'b1}}, 1'b0, 1'b0);
  endtask
  task automatic t_flags();
    mode(1'b0);
    wr(fap_pkg::FAP_ADR_PROT, 32'h1);
    cmd(fap_pkg::FAP_OP_WRITE, 1'b0, 4'h0, 8'h33, 1'b0);
    cmd(fap_pkg::FAP_OP_BLOCK, 1'b0, 4'h0, 8'h00, 1'b0);
    cmd(fap_pkg::FAP_OP_READ, 1'b0, 4'h0, 8'hff, 1'b1);
    mode(1'b1);
    cmd(fap_pkg::FAP_OP_WRITE, 1'b0, 4'h0, 8'h33, 1'b1);
    wr(fap_pkg::FAP_ADR_PROT, 32'h0);
    wr(fap_pkg::FAP_ADR_PROT, 32'h4);
    ck_prot(32'h5);
    mode(1'b0);
    cmd(fap_pkg::FAP_OP_CHIP, 1'b0, 4'h0, 8'h00, 1'b1);
    ck_prot(32'h0);
    wr(fap_pkg::FAP_ADR_PROT, 32'h8);
    cmd(fap_pkg::FAP_OP_READ, 1'b0, 4'h0, 8'h00, 1'b0);
    mode(1'b1);
    cmd(fap_pkg::FAP_OP_READ, 1'b0, 4'h0, 8'hff, 1'b1);
    mode(1'b0);
    wr(fap_pkg::FAP_ADR_PROT, 32'h2);
    cmd(fap_pkg::FAP_OP_BLOCK, 1'b0, 4'h0, 8'h00, 1'b0);
    cmd(fap_pkg::FAP_OP_CHIP, 1'b0, 4'h0, 8'h00, 1'b0);
    wr(fap_pkg::FAP_ADR_PROT, 32'h1);
    ck_prot(32'ha);
    mode(1'b1);
    cmd(fap_pkg::FAP_OP_BLOCK, 1'b0, 4'h0, 8'h00, 1'b1);
    cmd(fap_pkg::FAP_OP_CHIP, 1'b0, 4'h0, 8'h00, 1'b0);
    wr(fap_pkg::FAP_ADR_PROT, 32'h15);
    ck_prot(32'h1f);
    cmd(fap_pkg::FAP_OP_WRITE, 1'b1, 4'h1, 8'h11, 1'b0);
    mode(1'b0);
    for (int k = 0; k < 4; k++) begin
      cmd(2'(k), 1'b0, 4'h0, 8'h00, 1'b0);
    end
  endtask
  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // The whole run needs well under 3000 cycles; the margin covers a slow design.
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_debug();
    rstn <= 1'b0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_flags();
    summarize();
  end
endmodule // test_flash_access_protection
